// File: rtl/cmpctl_top.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "cmpctl_params.svh"

module cmpctl_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk,
  input  wire logic              rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Analog core results, asynchronous
  input  wire logic              raw_result,
  input  wire logic              filtered_result,
  // Processor side
  input  wire logic              global_irq_enable,
  input  wire logic              irq_serviced,
  output logic                   irq,
  // Controls toward the analog core and pins
  output logic                   comparator_power_on,
  output logic                   input_exchange,
  output logic                   output_filter_select,
  output logic                   reference_to_negative,
  output logic [1:0]             reference_level_select,
  output logic [3:0]             reference_level_onehot,
  output logic [1:0]             input_switch_select,
  output logic [7:0]             pin_buffer_disable,
  // Result toward software and the timer
  output logic                   comparison_result,
  output logic                   timer_capture_input
);
  import cmpctl_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [11:0] idx);
    logic [13:0] full;
    full = {idx, 2'b00};
    return full[ADDR_W-1:0];
  endfunction

  // Address decode, if and else-if chain
  function automatic cmpctl_reg_sel_t decode(input logic [ADDR_W-1:0] a);
    cmpctl_reg_sel_t sel;
    if (a == byte_addr(`CMPCTL_IDX_CTL_ONE)) begin
      sel = CMPCTL_SEL_CTL_ONE;
    end else if (a == byte_addr(`CMPCTL_IDX_CTL_TWO)) begin
      sel = CMPCTL_SEL_CTL_TWO;
    end else if (a == byte_addr(`CMPCTL_IDX_PIN_BUF)) begin
      sel = CMPCTL_SEL_PIN_BUF;
    end else if (a == byte_addr(`CMPCTL_IDX_IRQ_STATUS)) begin
      sel = CMPCTL_SEL_IRQ_STATUS;
    end else if (a == byte_addr(`CMPCTL_IDX_IRQ_MASK)) begin
      sel = CMPCTL_SEL_IRQ_MASK;
    end else begin
      sel = CMPCTL_SEL_NONE;
    end
    return sel;
  endfunction

  // One-hot enable for the reference generator taps
  function automatic logic [3:0] ref_decode(input logic [1:0] lvl);
    logic [3:0] oh;
    oh = 4'h0;
    case (cmpctl_ref_level_t'(lvl))
      CMPCTL_REF_OFF:     oh = 4'h1;
      CMPCTL_REF_QUARTER: oh = 4'h2;
      CMPCTL_REF_HALF:    oh = 4'h4;
      CMPCTL_REF_DIODE:   oh = 4'h8;
      default:            oh = 4'h1;
    endcase
    return oh;
  endfunction

  // ----------------------------------------------------------------
  // Result path ahead of the synchroniser
  // ----------------------------------------------------------------

  logic          picked_result;
  logic          synced_result;
  cmpctl_state_t state;
  cmpctl_state_t next_state;

  // Mux before syncing, so only one async signal crosses
  assign picked_result = state.filter_sel ? filtered_result
                                          : raw_result;

  // Async comparator output brought into the clock domain
  cmpctl_sync u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (picked_result),
    .sync_out (synced_result)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  always_comb begin
    cmpctl_reg_sel_t sel;
    logic            wr_en;
    logic            rd_setup;
    logic            on;
    logic            exch;
    logic            edge_pol;
    logic            rise;
    logic            fall;
    logic            event_set;
    logic            flag_clr;
    logic            flag_sw_set;
    logic [31:0]     rdata;

    sel         = decode(paddr);
    wr_en       = psel && penable && pready && pwrite;
    rd_setup    = psel && !penable;
    on          = 1'b0;
    exch        = 1'b0;
    edge_pol    = 1'b0;
    rise        = 1'b0;
    fall        = 1'b0;
    event_set   = 1'b0;
    flag_clr    = 1'b0;
    flag_sw_set = 1'b0;
    rdata       = 32'h0000_0000;
    next_state  = state;

    // Register writes take effect at the access edge only
    if (wr_en) begin
      case (sel)
        CMPCTL_SEL_CTL_ONE: begin
          next_state.ctl_one = pwdata[7:0];
          // Flag bit follows the written value
          flag_sw_set = pwdata[`CMPCTL_C1_EVENT_FLAG];
          flag_clr    = !pwdata[`CMPCTL_C1_EVENT_FLAG];
        end
        CMPCTL_SEL_CTL_TWO: begin
          next_state.filter_sel = pwdata[`CMPCTL_C2_FILTER];
          next_state.switch_sel =
            pwdata[`CMPCTL_C2_SWITCH_HI:`CMPCTL_C2_SWITCH_LO];
        end
        CMPCTL_SEL_PIN_BUF: begin
          next_state.pin_buf = pwdata[7:0];
        end
        CMPCTL_SEL_IRQ_STATUS: begin
          // Write one to clear
          flag_clr = pwdata[`CMPCTL_ST_EVENT];
        end
        CMPCTL_SEL_IRQ_MASK: begin
          next_state.irq_mask = pwdata[0];
        end
        default: begin
          next_state.ctl_one = state.ctl_one;
        end
      endcase
    end

    // Servicing the interrupt also clears the flag
    if (irq_serviced) begin
      flag_clr = 1'b1;
    end

    // Settings after this cycle's write
    on       = next_state.ctl_one[`CMPCTL_C1_POWER_ON];
    exch     = next_state.ctl_one[`CMPCTL_C1_EXCHANGE];
    edge_pol = next_state.ctl_one[`CMPCTL_C1_EDGE_POL];

    // Gated and polarity-corrected result
    if (!on) begin
      next_state.result = 1'b0;
    end else begin
      // Core reports plus above minus; undo the swap
      next_state.result = synced_result ^ exch;
    end
    next_state.result_prev = state.result;
    next_state.timer_cap   = next_state.result;

    // Edge detection on the registered result
    rise      = state.result && !state.result_prev;
    fall      = !state.result && state.result_prev;
    event_set = edge_pol ? fall : rise;

    // Set wins over any clear in the same cycle
    next_state.ctl_one[`CMPCTL_C1_EVENT_FLAG] =
      event_set || flag_sw_set ||
      (state.ctl_one[`CMPCTL_C1_EVENT_FLAG] && !flag_clr);

    // Interrupt level from the flag, the enable bit, the mask and the global enable
    next_state.irq = next_state.ctl_one[`CMPCTL_C1_EVENT_FLAG] &&
                     next_state.ctl_one[`CMPCTL_C1_IRQ_EN] &&
                     next_state.irq_mask &&
                     global_irq_enable;

    // Terminal for the reference flips with the exchange bit
    next_state.ref_to_neg =
      next_state.ctl_one[`CMPCTL_C1_REF_TERM] ^ exch;
    next_state.ref_onehot = ref_decode(
      next_state.ctl_one[`CMPCTL_C1_REF_LVL_HI:`CMPCTL_C1_REF_LVL_LO]);

    // Read data captured in the setup cycle
    case (sel)
      CMPCTL_SEL_CTL_ONE: begin
        rdata[7:0] = state.ctl_one;
      end
      CMPCTL_SEL_CTL_TWO: begin
        rdata[`CMPCTL_C2_RESULT] = state.result;
        rdata[`CMPCTL_C2_FILTER] = state.filter_sel;
        rdata[`CMPCTL_C2_SWITCH_HI:`CMPCTL_C2_SWITCH_LO] = state.switch_sel;
      end
      CMPCTL_SEL_PIN_BUF: begin
        rdata[7:0] = state.pin_buf;
      end
      CMPCTL_SEL_IRQ_STATUS: begin
        rdata[`CMPCTL_ST_EVENT] = state.ctl_one[`CMPCTL_C1_EVENT_FLAG];
      end
      CMPCTL_SEL_IRQ_MASK: begin
        rdata[0] = state.irq_mask;
      end
      default: begin
        rdata = 32'h0000_0000;
      end
    endcase

    // Registered answer costs one setup cycle, never more
    if (rd_setup) begin
      next_state.prdata  = pwrite ? 32'h0000_0000 : rdata;
      next_state.pslverr = (sel == CMPCTL_SEL_NONE);
      next_state.pready  = 1'b1;
    end else begin
      next_state.pready  = 1'b0;
      next_state.pslverr = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Every control bit starts from its power-on value
  always_ff @(posedge clk) begin
    if (rst) begin
      state            <= '0;
      state.ctl_one    <= `CMPCTL_RST_CTL_ONE;
      state.filter_sel <= 1'(`CMPCTL_RST_CTL_TWO >> `CMPCTL_C2_FILTER);
      state.switch_sel <= 2'h0;
      state.pin_buf    <= `CMPCTL_RST_PIN_BUF;
      state.irq_mask   <= `CMPCTL_RST_IRQ_MASK;
      state.ref_onehot <= 4'h1;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, each a flip-flop of the state
  // ----------------------------------------------------------------

  assign prdata                 = state.prdata;
  assign pready                 = state.pready;
  assign pslverr                = state.pslverr;
  assign irq                    = state.irq;
  assign comparator_power_on    = state.ctl_one[`CMPCTL_C1_POWER_ON];
  assign input_exchange         = state.ctl_one[`CMPCTL_C1_EXCHANGE];
  assign output_filter_select   = state.filter_sel;
  assign reference_to_negative  = state.ref_to_neg;
  assign reference_level_select =
    state.ctl_one[`CMPCTL_C1_REF_LVL_HI:`CMPCTL_C1_REF_LVL_LO];
  assign reference_level_onehot = state.ref_onehot;
  assign input_switch_select    = state.switch_sel;
  assign pin_buffer_disable     = state.pin_buf;
  assign comparison_result      = state.result;
  assign timer_capture_input    = state.timer_cap;

endmodule // cmpctl_top

// File: rtl/cmpctl_params.svh
`ifndef CMPCTL_PARAMS_SVH
`define CMPCTL_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define CMPCTL_IDX_CTL_ONE     12'h059
`define CMPCTL_IDX_CTL_TWO     12'h05a
`define CMPCTL_IDX_PIN_BUF     12'h05b
`define CMPCTL_IDX_IRQ_STATUS  12'h05c
`define CMPCTL_IDX_IRQ_MASK    12'h05d

// ----------------------------------------------------------------
// Control register one field positions
// ----------------------------------------------------------------
`define CMPCTL_C1_EXCHANGE     7
`define CMPCTL_C1_REF_TERM     6
`define CMPCTL_C1_REF_LVL_HI   5
`define CMPCTL_C1_REF_LVL_LO   4
`define CMPCTL_C1_POWER_ON     3
`define CMPCTL_C1_EDGE_POL     2
`define CMPCTL_C1_IRQ_EN       1
`define CMPCTL_C1_EVENT_FLAG   0

// ----------------------------------------------------------------
// Control register two and status field positions
// ----------------------------------------------------------------
`define CMPCTL_C2_RESULT       0
`define CMPCTL_C2_FILTER       1
`define CMPCTL_C2_SWITCH_HI    3
`define CMPCTL_C2_SWITCH_LO    2
`define CMPCTL_ST_EVENT        0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CMPCTL_RST_CTL_ONE     8'h00
`define CMPCTL_RST_CTL_TWO     8'h00
`define CMPCTL_RST_PIN_BUF     8'h00
`define CMPCTL_RST_IRQ_MASK    1'b0

`endif

// File: rtl/cmpctl_pkg.sv
package cmpctl_pkg;

  // Reference generator level, in register encoding order
  typedef enum logic [1:0] {
    CMPCTL_REF_OFF,
    CMPCTL_REF_QUARTER,
    CMPCTL_REF_HALF,
    CMPCTL_REF_DIODE
  } cmpctl_ref_level_t;

  // Register selected by an APB address
  typedef enum logic [2:0] {
    CMPCTL_SEL_CTL_ONE,
    CMPCTL_SEL_CTL_TWO,
    CMPCTL_SEL_PIN_BUF,
    CMPCTL_SEL_IRQ_STATUS,
    CMPCTL_SEL_IRQ_MASK,
    CMPCTL_SEL_NONE
  } cmpctl_reg_sel_t;

  // Synchroniser state
  typedef struct packed {
    logic meta;
    logic stable;
  } cmpctl_sync_state_t;

  // Whole state of the control block
  typedef struct packed {
    logic [7:0]  ctl_one;
    logic        filter_sel;
    logic [1:0]  switch_sel;
    logic [7:0]  pin_buf;
    logic        irq_mask;
    logic        result;
    logic        result_prev;
    logic        irq;
    logic        ref_to_neg;
    logic [3:0]  ref_onehot;
    logic        timer_cap;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } cmpctl_state_t;

endpackage

// File: rtl/cmpctl_sync.sv
`timescale 1ns/1ps

// Two-stage synchroniser for the asynchronous comparator output
module cmpctl_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      sync_out
);
  import cmpctl_pkg::*;

  cmpctl_sync_state_t state;
  cmpctl_sync_state_t next_state;

  // First stage feeds only the second stage
  always_comb begin
    next_state        = state;
    next_state.meta   = async_in;
    next_state.stable = state.meta;
  end

  // Both stages clear on reset
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.stable;

endmodule // cmpctl_sync

// File: tb/cmpctl_checker.sv
`timescale 1ns/1ps
// ------------
// Port checker
// ------------
module cmpctl_checker (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       raw_result,
  input wire logic       filtered_result,
  input wire logic       global_irq_enable,
  input wire logic       irq_serviced,
  input wire logic       irq,
  input wire logic       comparator_power_on,
  input wire logic       input_exchange,
  input wire logic       output_filter_select,
  input wire logic [1:0] reference_level_select,
  input wire logic [3:0] reference_level_onehot,
  input wire logic       comparison_result,
  input wire logic       timer_capture_input
);
  logic sel_in;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Core output chosen by the filter bit, three edges ahead of the result
  assign sel_in = output_filter_select ? filtered_result : raw_result;

  a_result_path: assert property (
    comparator_power_on && $past(comparator_power_on) &&
    $stable(input_exchange)
    |-> comparison_result == ($past(sel_in, 3) ^ input_exchange))
    else $error("result does not follow the selected core output");
  a_off_low: assert property (
    !comparator_power_on && !$past(comparator_power_on) |-> !comparison_result)
    else $error("result high while comparator off");
  a_timer_copy: assert property (
    timer_capture_input == comparison_result)
    else $error("timer capture input differs from result");
  a_level_onehot: assert property (
    $stable(reference_level_select)
    |-> reference_level_onehot == (4'h1 << reference_level_select))
    else $error("reference decode wrong");
  a_gie_blocks: assert property (
    !global_irq_enable && !$past(global_irq_enable) |-> !irq)
    else $error("irq without global enable");
  a_irq_cause: assert property (
    $rose(irq) && !$past(psel) && $past(global_irq_enable, 2)
    |-> $past(comparison_result) != $past(comparison_result, 2))
    else $error("irq rose without a result edge");
  a_service_clear: assert property (
    irq_serviced && !psel && $stable(comparison_result) |=> !irq)
    else $error("irq survives service");
  a_ready_setup: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  a_err_ready: assert property (
    pslverr |-> pready)
    else $error("pslverr without pready");

  c_irq: cover property ($rose(irq));
  c_result: cover property ($rose(comparison_result));
  c_err: cover property (pslverr);
  c_service: cover property (irq_serviced && irq);
endmodule // cmpctl_checker

bind cmpctl_top cmpctl_checker u_cmpctl_checker (
  .clk, .rst, .psel, .penable, .pready, .pslverr, .raw_result,
  .filtered_result, .global_irq_enable, .irq_serviced, .irq,
  .comparator_power_on, .input_exchange, .output_filter_select,
  .reference_level_select, .reference_level_onehot,
  .comparison_result, .timer_capture_input
);

// File: tb/cmpctl_core_model.sv
`timescale 1ns/1ps
// ------------
// Analog core
// ------------
module cmpctl_core_model #(
  parameter int FILT_DLY = 6
) (
  input  wire logic       clk,
  input  wire logic [7:0] pin_p,
  input  wire logic [7:0] pin_n,
  input  wire logic       ex,
  input  wire logic       ref_neg,
  input  wire logic [3:0] ref_oh,
  input  wire logic [1:0] sw,
  output logic            raw,
  output logic            filt
);
  logic [7:0]          vref, a, b, tp, tn;
  logic [FILT_DLY-1:0] rc;

  // Open switch leaves the terminal floating, read as ground here
  always_comb begin
    vref = ref_oh[1] ? 8'h40 : ref_oh[2] ? 8'h80 : 8'h8c;
    a = sw[0] ? pin_p : 8'h00;
    b = sw[1] ? pin_n : 8'h00;
    tp = ex ? b : a;
    tn = ex ? a : b;
    if (!ref_oh[0] && !ref_neg) tp = vref;
    if (!ref_oh[0] && ref_neg) tn = vref;
    raw = tp > tn;
  end

  // RC filter seen as a plain delay, slower than the raw path
  always_ff @(posedge clk) rc <= {rc[FILT_DLY-2:0], raw};
  assign filt = rc[FILT_DLY-1];
endmodule // cmpctl_core_model

// File: tb/cmpctl_top_test.sv
`timescale 1ns/1ps
module cmpctl_top_test;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic        raw_result, filtered_result, global_irq_enable;
  logic        irq_serviced, irq, comparator_power_on, input_exchange;
  logic        output_filter_select, reference_to_negative;
  logic        comparison_result, timer_capture_input;
  logic [1:0]  reference_level_select, input_switch_select;
  logic [3:0]  reference_level_onehot;
  logic [7:0]  pin_buffer_disable, pin_p, pin_n;
  logic [33:0] notes[$];
  int          miscompares, cmp_count;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  cmpctl_top u_cmpctl_top (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .raw_result, .filtered_result, .global_irq_enable,
    .irq_serviced, .irq, .comparator_power_on, .input_exchange,
    .output_filter_select, .reference_to_negative, .reference_level_select,
    .reference_level_onehot, .input_switch_select, .pin_buffer_disable,
    .comparison_result, .timer_capture_input
  );

  cmpctl_core_model u_cmpctl_core_model (
    .clk, .pin_p, .pin_n, .ex(input_exchange),
    .ref_neg(reference_to_negative), .ref_oh(reference_level_onehot),
    .sw(input_switch_select), .raw(raw_result), .filt(filtered_result)
  );

  // ------------
  // Helpers
  // ------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Note is {check data, pslverr, prdata}; bounded wait on pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d, input logic [33:0] nt);
    int n;
    notes.push_back(nt);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      miscompares++;
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 34'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] d);
    apb(1'b0, a, 8'h00, {2'b10, 24'h0, d});
  endtask

  // Completed transfers are matched against the oldest note
  always @(posedge clk) begin
    logic [33:0] nt;
    if (psel && penable && pready === 1'b1) begin
      nt = notes.pop_front();
      chk("pslverr", 8'(nt[32]), 8'(pslverr));
      if (nt[33]) chk("prdata", nt[7:0], prdata[7:0]);
    end
  end

  // ------------
  // Sequence
  // ------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pin_p, pin_n} = '0;
    {global_irq_enable, irq_serviced, miscompares, cmp_count} = '0;
    seed = 32'hc529;
    rst = 1'b1;
    cyc(4);
    rst <= 1'b0;
    cyc(1);
    chk("onehot", 8'h1, 8'(reference_level_onehot));
    rd(12'h164, 8'h00);
    rd(12'h168, 8'h00);
    rd(12'h174, 8'h00);
    apb(1'b0, 12'h180, 8'h00, {2'b11, 32'h0});
    wr(12'h168, 8'h01);
    rd(12'h168, 8'h00);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(12'h16c, seed[7:0]);
      rd(12'h16c, seed[7:0]);
      chk("pinbuf", seed[7:0], pin_buffer_disable);
      wr(12'h164, 8'(i << 4));
      cyc(1);
      chk("level", 8'(i), 8'(reference_level_select));
      chk("onehot", 8'h1 << i, 8'(reference_level_onehot));
    end
    // Result path: plain, exchanged, off, then through the filter
    wr(12'h168, 8'h0c);
    chk("switch", 8'h3, 8'(input_switch_select));
    pin_p <= 8'h90;
    pin_n <= 8'h80;
    wr(12'h164, 8'h08);
    chk("power", 8'h1, 8'(comparator_power_on));
    cyc(4);
    chk("result", 8'h1, 8'(comparison_result));
    chk("timer", 8'h1, 8'(timer_capture_input));
    rd(12'h168, 8'h0d);
    wr(12'h164, 8'h88);
    chk("exbit", 8'h1, 8'(input_exchange));
    cyc(4);
    chk("exch", 8'h1, 8'(comparison_result));
    chk("refneg", 8'h1, 8'(reference_to_negative));
    wr(12'h164, 8'h80);
    cyc(4);
    chk("off", 8'h0, 8'(comparison_result));
    wr(12'h168, 8'h0e);
    chk("filtsel", 8'h1, 8'(output_filter_select));
    wr(12'h164, 8'h08);
    cyc(12);
    pin_p <= 8'h10;
    cyc(4);
    chk("filt", 8'h1, 8'(comparison_result));
    cyc(8);
    chk("filt", 8'h0, 8'(comparison_result));
    // Reference on either terminal, then an open plus switch
    wr(12'h168, 8'h0c);
    pin_n <= 8'h40;
    wr(12'h164, 8'h28);
    cyc(4);
    chk("refp", 8'h1, 8'(comparison_result));
    wr(12'h164, 8'h68);
    cyc(4);
    chk("refn", 8'h0, 8'(comparison_result));
    pin_p <= 8'h90;
    wr(12'h168, 8'h08);
    wr(12'h164, 8'h08);
    cyc(4);
    chk("open", 8'h0, 8'(comparison_result));
    // Edge events, service, mask and global enable
    pin_p <= 8'h10;
    pin_n <= 8'h80;
    wr(12'h168, 8'h0c);
    wr(12'h174, 8'h01);
    wr(12'h164, 8'h0a);
    global_irq_enable <= 1'b1;
    cyc(6);
    wr(12'h170, 8'h01);
    chk("idle", 8'h0, 8'(irq));
    pin_p <= 8'h90;
    cyc(6);
    chk("rise", 8'h1, 8'(irq));
    rd(12'h170, 8'h01);
    irq_serviced <= 1'b1;
    cyc(1);
    irq_serviced <= 1'b0;
    cyc(2);
    chk("svc", 8'h0, 8'(irq));
    pin_p <= 8'h10;
    cyc(6);
    chk("fall", 8'h0, 8'(irq));
    wr(12'h164, 8'h0e);
    pin_p <= 8'h90;
    cyc(6);
    chk("rise2", 8'h0, 8'(irq));
    pin_p <= 8'h10;
    cyc(6);
    chk("fall2", 8'h1, 8'(irq));
    wr(12'h174, 8'h00);
    chk("mask", 8'h0, 8'(irq));
    wr(12'h174, 8'h01);
    global_irq_enable <= 1'b0;
    cyc(2);
    chk("gie", 8'h0, 8'(irq));
    global_irq_enable <= 1'b1;
    cyc(2);
    chk("gie", 8'h1, 8'(irq));
    wr(12'h170, 8'h01);
    chk("clr", 8'h0, 8'(irq));
    test_done();
  end
endmodule // cmpctl_top_test
